// ---- verification/btx_exec_monitor.sv ----
/*
  btx_exec_monitor: port assertions for btx_exec.
  assumes: bound to btx_exec; one clock, sync low reset.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========
// checker
module btx_exec_monitor
  import btx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // ports
  input wire logic cmd_valid,
  input wire btx_pkg::btx_cmd_t cmd,
  input wire logic busy,
  input wire logic done,
  input wire btx_pkg::btx_rf_wr_t rf_wr,
  input wire btx_pkg::btx_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input wire btx_pkg::btx_io_req_t io_req,
  input wire logic [7:0] io_rdata,
  input wire logic [7:0] status_register,
  input wire logic [15:0] stack_ptr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire tk = cmd_valid && !busy;
  wire sel_bit = cmd.reg_val[cmd.bit_sel];
  push_store_a: assert property (tk && cmd.op == BTX_OP_PUSH
    |-> mem_req.we && mem_req.addr == stack_ptr && done ##1 stack_ptr == $past(stack_ptr) - 16'h0001)
    else $error("push wrong");
  pop_load_a: assert property (tk && cmd.op == BTX_OP_POP |=> busy && done && mem_req.re
    && mem_req.addr == stack_ptr && stack_ptr == $past(stack_ptr) + 16'h0001 && rf_wr.wdata == mem_rdata)
    else $error("pop wrong");
  io_read_a: assert property (tk && cmd.op == BTX_OP_IO_IN |-> io_req.re && rf_wr.we
    && rf_wr.wdata == io_rdata ##1 $stable(status_register)) else $error("io read wrong");
  io_write_a: assert property (tk && cmd.op == BTX_OP_IO_OUT |-> io_req.we
    && io_req.addr == cmd.io_addr && io_req.wdata == cmd.reg_val) else $error("io write wrong");
  rmw_set_a: assert property (tk && cmd.op == BTX_OP_LOAD_AND_SET_MEM |=> mem_req.we
    && mem_req.wdata == (cmd.reg_val | mem_rdata) && rf_wr.wdata == mem_rdata) else $error("set wrong");
  shift_left_a: assert property (tk && cmd.op == BTX_OP_SHIFT_LEFT_LOGICAL
    |-> rf_wr.wdata == {cmd.reg_val[6:0], 1'b0} ##1 status_register[0] == $past(cmd.reg_val[7]))
    else $error("shift wrong");
  nibble_swap_a: assert property (tk && cmd.op == BTX_OP_NIBBLE_SWAP
    |-> rf_wr.wdata == {cmd.reg_val[3:0], cmd.reg_val[7:4]} ##1 $stable(status_register))
    else $error("swap wrong");
  bit_store_a: assert property (tk && cmd.op == BTX_OP_STORE_BIT_TO_TRANSFER
    |=> status_register[6] == $past(sel_bit)) else $error("bit store wrong");
  cover property (tk && cmd.op == BTX_OP_PUSH);
  cover property (tk && cmd.op == BTX_OP_POP);
  cover property (tk && cmd.op == BTX_OP_LOAD_AND_SET_MEM);
endmodule // btx_exec_monitor

bind btx_exec btx_exec_monitor u_mon (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
  .busy(busy), .done(done), .rf_wr(rf_wr), .mem_req(mem_req), .mem_rdata(mem_rdata),
  .io_req(io_req), .io_rdata(io_rdata), .status_register(status_register), .stack_ptr(stack_ptr));

`default_nettype wire

// ---- verification/btx_space_model.sv ----
/*
  btx_space_model: data memory and io space for btx_exec.
  assumes: reads answer at once on the address; writes land at the edge.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========
// memory and io model
module btx_space_model
  import btx_pkg::*;
(
  // clock
  input wire logic clk,
  // spaces
  input wire btx_pkg::btx_mem_req_t mem_req,
  output logic [7:0] mem_rdata,
  input wire btx_pkg::btx_io_req_t io_req,
  output logic [7:0] io_rdata
);
  logic [7:0] m [256];
  logic [7:0] io [64];
  initial
  begin
    for (int i = 0; i < 256; i++) m[i] = 8'(i);
    for (int i = 0; i < 64; i++) io[i] = 8'(i);
  end
  // released bus shows the inverse, so a stale byte never matches
  assign mem_rdata = mem_req.re ? m[mem_req.addr[7:0]] : ~m[mem_req.addr[7:0]];
  assign io_rdata = io_req.re ? io[io_req.addr] : ~io[io_req.addr];
  // read before write: rmw sees the old byte
  always @(posedge clk)
  begin
    if (mem_req.we) m[mem_req.addr[7:0]] <= mem_req.wdata;
    if (io_req.we) io[io_req.addr] <= io_req.wdata;
  end
endmodule // btx_space_model

`default_nettype wire

// ---- verification/tb_top.sv ----
/*
  tb_top: directed tests of btx_exec.
  assumes: model bytes start equal to their address.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========
// bench
module tb_top;
  import btx_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  btx_cmd_t cmd = '0;
  logic busy, done;
  btx_rf_wr_t rf_wr;
  btx_mem_req_t mem_req;
  btx_io_req_t io_req;
  logic [7:0] mem_rdata, io_rdata, sr, rv;
  logic [15:0] sp;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  btx_exec DUT (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd), .busy(busy),
    .done(done), .rf_wr(rf_wr), .mem_req(mem_req), .mem_rdata(mem_rdata), .io_req(io_req),
    .io_rdata(io_rdata), .status_register(sr), .stack_ptr(sp));
  btx_space_model P (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata), .io_req(io_req),
    .io_rdata(io_rdata));

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one instruction; cmd held until done, strobes read mid-cycle
  task automatic ex(input btx_op_t o, input logic [7:0] r, input logic [2:0] b = 3'h0,
    input logic [15:0] z = 16'h0000);
    @(negedge clk);
    cmd = '{o, r, z[5:0], b, z};
    cmd_valid = 1'b1;
    repeat (3)
    begin
      #10;
      if (rf_wr.we === 1'b1) rv = rf_wr.wdata;
      if (done === 1'b1) break;
      @(negedge clk);
    end
    chk8({7'h00, done}, 8'h01);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task automatic mc(input btx_op_t o, input logic [7:0] r, input logic [7:0] a,
    input logic [7:0] em);
    ex(o, r, 3'h0, {8'h00, a});
    chk8(rv, a);
    chk8(P.m[a], em);
  endtask

  task automatic sh(input btx_op_t o, input logic [7:0] r, input logic [7:0] er,
    input logic [7:0] ef);
    ex(o, r);
    chk8(rv, er);
    chk8(sr & 8'h3f, ef);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      close_out;
    end
  end

  initial
  begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    chk8(sr, BTX_STATUS_REGISTER_RST);
    chk16(sp, BTX_SP_RST);
    // ==========
    // stack and memory
    ex(BTX_OP_PUSH, 8'ha5);
    chk8(P.m[8'hff], 8'ha5);
    chk16(sp, 16'hfffe);
    ex(BTX_OP_POP, 8'h00);
    chk8(rv, 8'ha5);
    chk16(sp, 16'hffff);
    mc(BTX_OP_EXCHANGE_MEM, 8'h3c, 8'h10, 8'h3c);
    mc(BTX_OP_LOAD_AND_SET_MEM, 8'h03, 8'h20, 8'h23);
    mc(BTX_OP_LOAD_AND_CLEAR_MEM, 8'h0f, 8'h33, 8'h30);
    mc(BTX_OP_LOAD_AND_TOGGLE_MEM, 8'hff, 8'h40, 8'hbf);
    chk8(sr, 8'h00);
    $display("test memory done");
    // ==========
    // io space
    ex(BTX_OP_IO_IN, 8'h00, 3'h0, 16'h0005);
    chk8(rv, 8'h05);
    ex(BTX_OP_IO_OUT, 8'h77, 3'h0, 16'h0006);
    chk8(P.io[6], 8'h77);
    ex(BTX_OP_IO_BIT_SET, 8'h00, 3'h3, 16'h0006);
    chk8(P.io[6], 8'h7f);
    ex(BTX_OP_IO_BIT_CLEAR, 8'h00, 3'h0, 16'h0006);
    chk8(P.io[6], 8'h7e);
    chk8(sr, 8'h00);
    $display("test io done");
    // ==========
    // flags, every position up then down
    for (int i = 0; i < 8; i++)
    begin
      ex(BTX_OP_STATUS_BIT_SET, 8'h00, 3'(i));
      chk8(sr, 8'hff >> (7 - i));
    end
    for (int i = 0; i < 8; i++)
    begin
      ex(BTX_OP_STATUS_BIT_CLEAR, 8'h00, 3'(i));
      chk8(sr, 8'hff << (i + 1));
    end
    $display("test flags done");
    // ==========
    // shifts and bits; flags h s v n z c
    sh(BTX_OP_SHIFT_LEFT_LOGICAL, 8'h81, 8'h02, 8'h19);
    sh(BTX_OP_ROTATE_LEFT_CARRY, 8'h40, 8'h81, 8'h0c);
    sh(BTX_OP_SHIFT_RIGHT_LOGICAL, 8'h01, 8'h00, 8'h1b);
    sh(BTX_OP_ROTATE_RIGHT_CARRY, 8'h02, 8'h81, 8'h0c);
    sh(BTX_OP_SHIFT_RIGHT_ARITH, 8'h84, 8'hc2, 8'h0c);
    sh(BTX_OP_NIBBLE_SWAP, 8'h12, 8'h21, 8'h0c);
    ex(BTX_OP_STORE_BIT_TO_TRANSFER, 8'h08, 3'h3);
    chk8(sr & 8'h40, 8'h40);
    ex(BTX_OP_LOAD_BIT_FROM_TRANSFER, 8'h00, 3'h5);
    chk8(rv, 8'h20);
    $display("test bits done");
    close_out;
  end
endmodule // tb_top

`default_nettype wire

// ---- verilog/btx_exec.sv ----
/*
  btx_exec: execution datapath for transfer and bit instructions.
  assumes: memory and io reads return data combinationally in the
  same cycle as the read strobe; the decoder holds cmd while busy is
  high and offers a new one only when busy is low.
*/
`timescale 1ns/1ps
`default_nettype none

module btx_exec
  import btx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // decoded command
  input wire logic cmd_valid,
  input wire btx_pkg::btx_cmd_t cmd,
  output logic busy,
  output logic done,
  // register file write back
  output btx_pkg::btx_rf_wr_t rf_wr,
  // data memory
  output btx_pkg::btx_mem_req_t mem_req,
  input wire logic [btx_pkg::BTX_DW-1:0] mem_rdata,
  // io space
  output btx_pkg::btx_io_req_t io_req,
  input wire logic [btx_pkg::BTX_DW-1:0] io_rdata,
  // state visible to the core
  output logic [btx_pkg::BTX_DW-1:0] status_register,
  output logic [btx_pkg::BTX_AW-1:0] stack_ptr
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {BTX_ST_IDLE, BTX_ST_POP2, BTX_ST_RMW2} btx_state_t;

  btx_state_t state_q, state_d;
  logic [BTX_DW-1:0] status_register_q, status_register_d;
  logic [BTX_AW-1:0] sp_q, sp_d;
  btx_cmd_t hold_q, hold_d;
  btx_rf_wr_t rf_q, rf_d;
  btx_mem_req_t mem_d;
  btx_io_req_t io_d;
  logic done_q, done_d;

  // one-hot of the selected bit, used for io, status and transfer ops
  function automatic logic [BTX_DW-1:0] bit_mask(input logic [BTX_BSELW-1:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

  // ==========================================================
  // bit positions inside a data byte
  localparam int MSB = BTX_DW - 1;
  localparam int HALF = BTX_DW / 2;
  // half carry of a left move reports the old low-nibble top bit
  localparam int H_SRC = HALF - 1;

  // ==========================================================
  // shifter and flag datapath
  wire logic [BTX_DW-1:0] rv = cmd.reg_val;
  wire logic [BTX_DW-1:0] mask = bit_mask(cmd.bit_sel);
  wire logic c_old = status_register_q[BTX_F_C];
  wire logic [BTX_DW-1:0] lsl_r = {rv[MSB-1:0], 1'b0};
  wire logic [BTX_DW-1:0] lsr_r = {1'b0, rv[MSB:1]};
  wire logic [BTX_DW-1:0] rol_r = {rv[MSB-1:0], c_old};
  wire logic [BTX_DW-1:0] ror_r = {c_old, rv[MSB:1]};
  wire logic [BTX_DW-1:0] asr_r = {rv[MSB], rv[MSB:1]};
  wire logic [BTX_DW-1:0] swp_r = {rv[HALF-1:0], rv[MSB:HALF]};
  wire logic left_op = (cmd.op == BTX_OP_SHIFT_LEFT_LOGICAL)
                     || (cmd.op == BTX_OP_ROTATE_LEFT_CARRY);
  wire logic [BTX_DW-1:0] sh_r =
    (cmd.op == BTX_OP_SHIFT_LEFT_LOGICAL) ? lsl_r :
    (cmd.op == BTX_OP_SHIFT_RIGHT_LOGICAL) ? lsr_r :
    (cmd.op == BTX_OP_ROTATE_LEFT_CARRY) ? rol_r :
    (cmd.op == BTX_OP_ROTATE_RIGHT_CARRY) ? ror_r : asr_r;
  // carry out is bit 7 for left moves and bit 0 for right moves
  wire logic sh_c = left_op ? rv[MSB] : rv[0];
  wire logic sh_n = sh_r[MSB];
  wire logic sh_v = sh_n ^ sh_c;
  wire logic sh_z = (sh_r == '0);
  wire logic sh_s = sh_n ^ sh_v;
  logic [BTX_DW-1:0] sh_status_register;

  // ==========================================================
  // flag image after a shift or rotate
  // each flag placed by its named position, so a moved bit
  // in the status layout cannot silently land in the wrong place
  always_comb
  begin
    sh_status_register = status_register_q;
    sh_status_register[BTX_F_C] = sh_c;
    sh_status_register[BTX_F_Z] = sh_z;
    sh_status_register[BTX_F_N] = sh_n;
    sh_status_register[BTX_F_V] = sh_v;
    sh_status_register[BTX_F_S] = sh_s;
    // right moves leave half carry alone
    if (left_op)
    begin
      sh_status_register[BTX_F_H] = rv[H_SRC];
    end
  end

  // read-modify-write results, computed from held register and memory
  wire logic [BTX_DW-1:0] rmw_mem =
    (hold_q.op == BTX_OP_LOAD_AND_SET_MEM) ? (hold_q.reg_val | mem_rdata) :
    (hold_q.op == BTX_OP_LOAD_AND_CLEAR_MEM) ? (~hold_q.reg_val & mem_rdata) :
    (hold_q.op == BTX_OP_LOAD_AND_TOGGLE_MEM) ? (hold_q.reg_val ^ mem_rdata) :
    hold_q.reg_val;

  wire logic take = cmd_valid && (state_q == BTX_ST_IDLE);

  // ==========================================================
  // next state
  always_comb
  begin
    state_d = state_q;
    status_register_d = status_register_q;
    sp_d = sp_q;
    hold_d = hold_q;
    rf_d = '0;
    mem_d = '0;
    io_d = '0;
    done_d = 1'b0;
    case (state_q)
      BTX_ST_IDLE:
      begin
        if (take)
        begin
          hold_d = cmd;
          case (cmd.op)
            BTX_OP_IO_IN:
            begin
              io_d.re = 1'b1;
              io_d.addr = cmd.io_addr;
              rf_d = '{we: 1'b1, wdata: io_rdata};
              done_d = 1'b1;
            end
            BTX_OP_IO_OUT:
            begin
              io_d = '{re: 1'b0, we: 1'b1, addr: cmd.io_addr, wdata: rv};
              done_d = 1'b1;
            end
            BTX_OP_PUSH:
            begin
              mem_d = '{re: 1'b0, we: 1'b1, addr: sp_q, wdata: rv};
              sp_d = sp_q - BTX_SP_STEP;
              done_d = 1'b1;
            end
            BTX_OP_POP:
            begin
              sp_d = sp_q + BTX_SP_STEP;
              state_d = BTX_ST_POP2;
            end
            BTX_OP_EXCHANGE_MEM, BTX_OP_LOAD_AND_SET_MEM,
            BTX_OP_LOAD_AND_CLEAR_MEM, BTX_OP_LOAD_AND_TOGGLE_MEM:
              state_d = BTX_ST_RMW2;
            BTX_OP_SHIFT_LEFT_LOGICAL, BTX_OP_SHIFT_RIGHT_LOGICAL,
            BTX_OP_ROTATE_LEFT_CARRY, BTX_OP_ROTATE_RIGHT_CARRY,
            BTX_OP_SHIFT_RIGHT_ARITH:
            begin
              rf_d = '{we: 1'b1, wdata: sh_r};
              status_register_d = sh_status_register;
              done_d = 1'b1;
            end
            BTX_OP_NIBBLE_SWAP:
            begin
              rf_d = '{we: 1'b1, wdata: swp_r};
              done_d = 1'b1;
            end
            // generic flag ops set or clear whichever status bit bit_sel picks
            BTX_OP_STATUS_BIT_SET:
            begin
              status_register_d = status_register_q | mask;
              done_d = 1'b1;
            end
            BTX_OP_STATUS_BIT_CLEAR:
            begin
              status_register_d = status_register_q & ~mask;
              done_d = 1'b1;
            end
            BTX_OP_IO_BIT_SET, BTX_OP_IO_BIT_CLEAR:
            begin
              io_d.re = 1'b1;
              io_d.we = 1'b1;
              io_d.addr = cmd.io_addr;
              io_d.wdata = (cmd.op == BTX_OP_IO_BIT_SET)
                ? (io_rdata | mask) : (io_rdata & ~mask);
              done_d = 1'b1;
            end
            BTX_OP_STORE_BIT_TO_TRANSFER:
            begin
              status_register_d[BTX_F_T] = |(rv & mask);
              done_d = 1'b1;
            end
            BTX_OP_LOAD_BIT_FROM_TRANSFER:
            begin
              rf_d.we = 1'b1;
              rf_d.wdata = status_register_q[BTX_F_T] ? (rv | mask) : (rv & ~mask);
              done_d = 1'b1;
            end
            default:
              done_d = 1'b1;
          endcase
        end
      end
      BTX_ST_POP2:
      begin
        mem_d.re = 1'b1;
        mem_d.addr = sp_q;
        rf_d = '{we: 1'b1, wdata: mem_rdata};
        done_d = 1'b1;
        state_d = BTX_ST_IDLE;
      end
      BTX_ST_RMW2:
      begin
        // second cycle reads and writes the same byte; memory must give
        // old data before the write lands at the edge
        mem_d = '{re: 1'b1, we: 1'b1, addr: hold_q.z_ptr, wdata: rmw_mem};
        rf_d = '{we: 1'b1, wdata: mem_rdata};
        done_d = 1'b1;
        state_d = BTX_ST_IDLE;
      end
      default:
        state_d = BTX_ST_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q <= BTX_ST_IDLE;
      status_register_q <= BTX_STATUS_REGISTER_RST;
      sp_q <= BTX_SP_RST;
      hold_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      status_register_q <= status_register_d;
      sp_q <= sp_d;
      hold_q <= hold_d;
      done_q <= done_d;
    end
  end

  // ==========================================================
  // outputs: strobes combinational so memory and io see them in-cycle
  assign rf_wr = rf_d;
  assign mem_req = mem_d;
  assign io_req = io_d;
  assign busy = (state_q != BTX_ST_IDLE);
  assign done = done_d;
  assign status_register = status_register_q;
  assign stack_ptr = sp_q;

  // done_q kept as a registered copy of done; no logic reads it and it is not an output
  wire logic unused_done_q = done_q;

endmodule // btx_exec

`default_nettype wire

// ---- verilog/btx_pkg.sv ----
/*
  btx_pkg: shared constants, operation codes and carriers for the
  bit and transfer execution datapath.
  assumes: one clock domain; the decoder supplies a decoded opcode.
*/
`default_nettype none

package btx_pkg;

  // ==========================================================
  // widths and status bit positions
  localparam int BTX_DW = 8;
  localparam int BTX_AW = 16;
  localparam int BTX_IOAW = 6;
  localparam int BTX_BSELW = 3;
  localparam int BTX_F_C = 0;
  localparam int BTX_F_Z = 1;
  localparam int BTX_F_N = 2;
  localparam int BTX_F_V = 3;
  localparam int BTX_F_S = 4;
  localparam int BTX_F_H = 5;
  localparam int BTX_F_T = 6;
  localparam int BTX_F_I = 7;
  localparam logic [7:0] BTX_STATUS_REGISTER_RST = 8'h00;
  localparam logic [15:0] BTX_SP_RST = 16'hffff;
  localparam logic [15:0] BTX_SP_STEP = 16'h0001;

  // ==========================================================
  // operations
  typedef enum logic [4:0] {
    BTX_OP_NOP,
    BTX_OP_IO_IN,
    BTX_OP_IO_OUT,
    BTX_OP_PUSH,
    BTX_OP_POP,
    BTX_OP_EXCHANGE_MEM,
    BTX_OP_LOAD_AND_SET_MEM,
    BTX_OP_LOAD_AND_CLEAR_MEM,
    BTX_OP_LOAD_AND_TOGGLE_MEM,
    BTX_OP_SHIFT_LEFT_LOGICAL,
    BTX_OP_SHIFT_RIGHT_LOGICAL,
    BTX_OP_ROTATE_LEFT_CARRY,
    BTX_OP_ROTATE_RIGHT_CARRY,
    BTX_OP_SHIFT_RIGHT_ARITH,
    BTX_OP_NIBBLE_SWAP,
    BTX_OP_STATUS_BIT_SET,
    BTX_OP_STATUS_BIT_CLEAR,
    BTX_OP_IO_BIT_SET,
    BTX_OP_IO_BIT_CLEAR,
    BTX_OP_STORE_BIT_TO_TRANSFER,
    BTX_OP_LOAD_BIT_FROM_TRANSFER
  } btx_op_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    btx_op_t op;
    logic [BTX_DW-1:0] reg_val;
    logic [BTX_IOAW-1:0] io_addr;
    logic [BTX_BSELW-1:0] bit_sel;
    logic [BTX_AW-1:0] z_ptr;
  } btx_cmd_t;

  typedef struct packed {
    logic we;
    logic [BTX_DW-1:0] wdata;
  } btx_rf_wr_t;

  typedef struct packed {
    logic re;
    logic we;
    logic [BTX_AW-1:0] addr;
    logic [BTX_DW-1:0] wdata;
  } btx_mem_req_t;

  typedef struct packed {
    logic re;
    logic we;
    logic [BTX_IOAW-1:0] addr;
    logic [BTX_DW-1:0] wdata;
  } btx_io_req_t;

endpackage

`default_nettype wire
